// *** rtl/ccx_core.sv ***
// Call-and-clear executor with AHB-Lite register access
`timescale 1ns/10ps
module ccx_core #(
    parameter int DOG_W = 8,
    parameter int PRE_W = 8
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp
);

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic busy;
    logic wr_en;
    logic [31:0] next_rdata;

    ccx_pkg::ccx_state_t state;
    logic [11:0] instr;
    logic [10:0] program_counter;
    logic [10:0] stack_head_entry;
    logic [10:0] stack_low_entry;
    logic [7:0] status;
    logic [7:0] wreg;
    logic [7:0] file_mem [32];
    logic [DOG_W-1:0] watchdog_counter;
    logic [PRE_W-1:0] prescaler;
    logic pre_on_dog;

    ccx_pkg::ccx_op_t op;
    logic [7:0] imm_k;
    logic [4:0] file_addr;
    logic exec;
    logic do_call;
    logic do_file_clr;
    logic do_wreg_clr;
    logic do_dog_clr;
    logic pre_tick;
    logic dog_expire;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hready) begin
            dp_valid <= hsel && htrans[1];
            dp_write <= hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    // Writes stall while an instruction runs, so software and the executor
    // never update the same register in one cycle.
    assign busy = (state != ccx_pkg::CCX_IDLE);
    assign hreadyout = !(dp_valid && dp_write && busy);
    assign wr_en = dp_valid && dp_write && !busy;
    assign hresp = 1'b0;

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (haddr[7:0] >= ccx_pkg::CCX_OFS_FILE) begin
            next_rdata[7:0] = file_mem[haddr[6:2]];
        end else begin
            case (haddr[7:0])
                ccx_pkg::CCX_OFS_INSTR: begin
                    next_rdata[11:0] = instr;
                    next_rdata[ccx_pkg::CCX_BUSY_BIT] = busy;
                end
                ccx_pkg::CCX_OFS_PROG: next_rdata[10:0] = program_counter;
                ccx_pkg::CCX_OFS_STATUS: next_rdata[7:0] = status;
                ccx_pkg::CCX_OFS_WREG: next_rdata[7:0] = wreg;
                ccx_pkg::CCX_OFS_STACK: begin
                    next_rdata[10:0] = stack_head_entry;
                    next_rdata[ccx_pkg::CCX_STK_HI_LSB +: 11] = stack_low_entry;
                end
                ccx_pkg::CCX_OFS_DOG: begin
                    next_rdata[DOG_W-1:0] = watchdog_counter;
                    next_rdata[16 +: PRE_W] = prescaler;
                end
                ccx_pkg::CCX_OFS_CTRL: next_rdata[ccx_pkg::CCX_CTRL_PSA] = pre_on_dog;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    ccx_decode u_decode (
        .opcode(instr),
        .op(op),
        .imm_k(imm_k),
        .file_addr(file_addr)
    );

    assign exec = (state == ccx_pkg::CCX_EXEC);
    assign do_call = exec && (op == ccx_pkg::CCX_OP_CALL);
    assign do_file_clr = exec && (op == ccx_pkg::CCX_OP_FILE_CLR);
    assign do_wreg_clr = exec && (op == ccx_pkg::CCX_OP_WREG_CLR);
    assign do_dog_clr = exec && (op == ccx_pkg::CCX_OP_DOG_CLR);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            instr <= ccx_pkg::CCX_INSTR_RST;
        end else if (wr_en && dp_addr == ccx_pkg::CCX_OFS_INSTR) begin
            instr <= hwdata[11:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= ccx_pkg::CCX_IDLE;
        end else begin
            case (state)
                ccx_pkg::CCX_IDLE: begin
                    if (wr_en && dp_addr == ccx_pkg::CCX_OFS_INSTR) begin
                        state <= ccx_pkg::CCX_EXEC;
                    end
                end
                ccx_pkg::CCX_EXEC: begin
                    // The call spends a second cycle while the fetch refills
                    if (do_call) begin // [RULE1]
                        state <= ccx_pkg::CCX_CALL2;
                    end else begin
                        state <= ccx_pkg::CCX_IDLE;
                    end
                end
                ccx_pkg::CCX_CALL2: state <= ccx_pkg::CCX_IDLE;
                default: state <= ccx_pkg::CCX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Program counter and stack
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            program_counter <= ccx_pkg::CCX_PROG_RST;
        end else if (wr_en && dp_addr == ccx_pkg::CCX_OFS_PROG) begin
            program_counter <= hwdata[10:0];
        end else if (do_call) begin
            program_counter <= {status[ccx_pkg::CCX_ST_PG_HI:ccx_pkg::CCX_ST_PG_LO], 1'b0, imm_k}; // [RULE1] [RULE3]
        end else if (exec) begin
            program_counter <= program_counter + 11'd1;
        end
    end

    // Two-level stack: the older entry falls off the bottom on overflow
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stack_head_entry <= 11'h000;
            stack_low_entry <= 11'h000;
        end else if (do_call) begin
            stack_head_entry <= program_counter + 11'd1; // [RULE2]
            stack_low_entry <= stack_head_entry;
        end
    end

    // ----------------------------------------------------------------
    // Status, working register, file registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            status <= ccx_pkg::CCX_STATUS_RST;
        end else if (wr_en && dp_addr == ccx_pkg::CCX_OFS_STATUS) begin
            status <= hwdata[7:0];
            // An expiry that meets a software write must not be lost
            if (dog_expire) begin
                status[ccx_pkg::CCX_ST_EXPIRY] <= 1'b0;
            end
        end else begin
            if (do_file_clr || do_wreg_clr) begin
                status[ccx_pkg::CCX_ST_Z] <= 1'b1; // [RULE4] [RULE5]
            end
            if (do_dog_clr) begin
                status[ccx_pkg::CCX_ST_EXPIRY] <= 1'b1; // [RULE8]
                status[ccx_pkg::CCX_ST_PWRDN] <= 1'b1; // [RULE8]
            end else if (dog_expire) begin
                status[ccx_pkg::CCX_ST_EXPIRY] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wreg <= 8'h00;
        end else if (wr_en && dp_addr == ccx_pkg::CCX_OFS_WREG) begin
            wreg <= hwdata[7:0];
        end else if (do_wreg_clr) begin
            wreg <= 8'h00; // [RULE5]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < 32; i++) begin
                file_mem[i] <= 8'h00;
            end
        end else if (wr_en && dp_addr >= ccx_pkg::CCX_OFS_FILE) begin
            file_mem[dp_addr[6:2]] <= hwdata[7:0];
        end else if (do_file_clr) begin
            file_mem[file_addr] <= 8'h00; // [RULE4]
        end
    end

    // ----------------------------------------------------------------
    // Watchdog and shared prescaler
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pre_on_dog <= ccx_pkg::CCX_PSA_RST;
        end else if (wr_en && dp_addr == ccx_pkg::CCX_OFS_CTRL) begin
            pre_on_dog <= hwdata[ccx_pkg::CCX_CTRL_PSA];
        end
    end

    assign pre_tick = pre_on_dog ? (&prescaler) : 1'b1;
    assign dog_expire = pre_tick && (&watchdog_counter) && !do_dog_clr;

    // Timer side of the prescaler is outside this block, so it holds here
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prescaler <= '0;
        end else if (do_dog_clr && pre_on_dog) begin
            prescaler <= '0; // [RULE7]
        end else if (pre_on_dog) begin
            prescaler <= prescaler + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            watchdog_counter <= '0;
        end else if (do_dog_clr) begin
            watchdog_counter <= '0; // [RULE6]
        end else if (pre_tick) begin
            watchdog_counter <= watchdog_counter + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_call_exec;
        exec && op == ccx_pkg::CCX_OP_CALL;
    endsequence

    sequence s_call_tail;
        state == ccx_pkg::CCX_CALL2 ##1 state == ccx_pkg::CCX_IDLE;
    endsequence

    chk_call_target: assert property (@(posedge ref_clk) disable iff (srst) // [RULE1] [RULE3]
        s_call_exec |=> program_counter == {$past(status[6:5]), 1'b0, $past(imm_k)})
        else $error("call target not composed from page bits and k");

    chk_call_cycles: assert property (@(posedge ref_clk) disable iff (srst) // [RULE1]
        s_call_exec |=> s_call_tail)
        else $error("call did not take two cycles");

    chk_call_push: assert property (@(posedge ref_clk) disable iff (srst) // [RULE2]
        s_call_exec |=> stack_head_entry == $past(program_counter) + 11'd1
            && stack_low_entry == $past(stack_head_entry))
        else $error("return address not pushed");

    chk_call_flags: assert property (@(posedge ref_clk) disable iff (srst) // [RULE2]
        s_call_exec |=> status[6:2] == $past(status[6:2]) || $past(dog_expire))
        else $error("call changed status flags");

    chk_file_clear: assert property (@(posedge ref_clk) disable iff (srst) // [RULE4]
        exec && op == ccx_pkg::CCX_OP_FILE_CLR |=> file_mem[$past(file_addr)] == 8'h00
            && status[2] && state == ccx_pkg::CCX_IDLE)
        else $error("file register clear failed");

    chk_wreg_clear: assert property (@(posedge ref_clk) disable iff (srst) // [RULE5]
        exec && op == ccx_pkg::CCX_OP_WREG_CLR |=> wreg == 8'h00 && status[2] && !busy)
        else $error("working register clear failed");

    chk_dog_reset: assert property (@(posedge ref_clk) disable iff (srst) // [RULE6]
        exec && op == ccx_pkg::CCX_OP_DOG_CLR |=> watchdog_counter == '0 && state == ccx_pkg::CCX_IDLE)
        else $error("watchdog not cleared");

    chk_pre_assigned: assert property (@(posedge ref_clk) disable iff (srst) // [RULE7]
        exec && op == ccx_pkg::CCX_OP_DOG_CLR |=> prescaler == ($past(pre_on_dog) ? '0 : $past(prescaler)))
        else $error("prescaler clear ignored its assignment");

    chk_dog_flags: assert property (@(posedge ref_clk) disable iff (srst) // [RULE8]
        exec && op == ccx_pkg::CCX_OP_DOG_CLR |=> status[4] && status[3])
        else $error("timeout and power-down flags not set");

endmodule : ccx_core

// *** rtl/ccx_pkg.sv ***
// Package of constants and types for the call-and-clear instruction executor
//
// Contract
// RULE1: The call opcode carries an 8-bit target k (0..255) that lands in program_counter[7:0], taking two cycles.
// RULE2: A call pushes program_counter plus one onto stack_head_entry first and changes no status flag.
// RULE3: A call copies status[6:5] into program_counter[10:9] and clears program_counter[8].
// RULE4: file_register_clear_op zeroes the addressed file register (0..31) and sets the zero flag in one cycle.
// RULE5: working_reg_clear_op zeroes the working register and sets the zero flag in one cycle.
// RULE6: watchdog_clear_op resets watchdog_counter to zero in one cycle.
// RULE7: watchdog_clear_op also clears the prescaler only while it is assigned to the watchdog.
// RULE8: watchdog_clear_op sets watchdog_expiry_flag and power_down_flag to one.
package ccx_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses, low 8 bits)
    // ----------------------------------------------------------------
    localparam logic [7:0] CCX_OFS_INSTR = 8'h00;
    localparam logic [7:0] CCX_OFS_PROG = 8'h04;
    localparam logic [7:0] CCX_OFS_STATUS = 8'h08;
    localparam logic [7:0] CCX_OFS_WREG = 8'h0C;
    localparam logic [7:0] CCX_OFS_STACK = 8'h10;
    localparam logic [7:0] CCX_OFS_DOG = 8'h14;
    localparam logic [7:0] CCX_OFS_CTRL = 8'h18;
    localparam logic [7:0] CCX_OFS_FILE = 8'h80;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CCX_ST_Z = 2;
    localparam int CCX_ST_PWRDN = 3;
    localparam int CCX_ST_EXPIRY = 4;
    localparam int CCX_ST_PG_LO = 5;
    localparam int CCX_ST_PG_HI = 6;
    localparam int CCX_BUSY_BIT = 31;
    localparam int CCX_CTRL_PSA = 0;
    localparam int CCX_STK_HI_LSB = 16;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CCX_STATUS_RST = 8'h18;
    localparam logic [10:0] CCX_PROG_RST = 11'h000;
    localparam logic [11:0] CCX_INSTR_RST = 12'h000;
    localparam logic CCX_PSA_RST = 1'b1;

    // ----------------------------------------------------------------
    // Opcodes and timing
    // ----------------------------------------------------------------
    localparam logic [3:0] CCX_CALL_HI = 4'h9;
    localparam logic [6:0] CCX_FILE_CLR_HI = 7'h03;
    localparam logic [11:0] CCX_WREG_CLR_OP = 12'h040;
    localparam logic [11:0] CCX_DOG_CLR_OP = 12'h004;
    localparam int CCX_CALL_CYCLES = 2;

    typedef enum logic [2:0] {
        CCX_IDLE = 3'b001,
        CCX_EXEC = 3'b010,
        CCX_CALL2 = 3'b100
    } ccx_state_t;

    typedef enum logic [4:0] {
        CCX_OP_OTHER = 5'b00001,
        CCX_OP_CALL = 5'b00010,
        CCX_OP_FILE_CLR = 5'b00100,
        CCX_OP_WREG_CLR = 5'b01000,
        CCX_OP_DOG_CLR = 5'b10000
    } ccx_op_t;

endpackage : ccx_pkg

// *** rtl/ccx_decode.sv ***
// Opcode decoder for the call and clear instructions
`timescale 1ns/10ps
module ccx_decode (
    input wire logic [11:0] opcode,
    output ccx_pkg::ccx_op_t op,
    output logic [7:0] imm_k,
    output logic [4:0] file_addr
);

    always_comb begin
        if (opcode[11:8] == ccx_pkg::CCX_CALL_HI) begin // [RULE1]
            op = ccx_pkg::CCX_OP_CALL;
        end else if (opcode[11:5] == ccx_pkg::CCX_FILE_CLR_HI) begin // [RULE4]
            op = ccx_pkg::CCX_OP_FILE_CLR;
        end else if (opcode == ccx_pkg::CCX_WREG_CLR_OP) begin // [RULE5]
            op = ccx_pkg::CCX_OP_WREG_CLR;
        end else if (opcode == ccx_pkg::CCX_DOG_CLR_OP) begin // [RULE6]
            op = ccx_pkg::CCX_OP_DOG_CLR;
        end else begin
            op = ccx_pkg::CCX_OP_OTHER;
        end
    end

    assign imm_k = opcode[7:0];
    assign file_addr = opcode[4:0];

endmodule : ccx_decode

// *** tb/ccx_core_tb.sv ***
// Self-checking testbench for the call-and-clear executor
`timescale 1ns/10ps
module ccx_core_tb;
    logic ref_clk;
    logic srst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    int mismatches;
    int n_checks;
    logic [31:0] seed;
    logic [31:0] rd;
    logic psa;
    logic [7:0] k;
    logic [7:0] sts;
    logic [10:0] pc0;
    logic [10:0] hd;
    logic [4:0] f;
    logic [7:0] p0;
    int st;

    // The slave's own ready closes the loop as the bus ready
    ccx_core DUT (.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [7:0] fa(input logic [4:0] idx);
        return ccx_pkg::CCX_OFS_FILE + {1'b0, idx, 2'b00};
    endfunction : fa

    // Call target: page bits from status, bit eight cleared, k in the low byte
    function automatic logic [31:0] exp_call_pc(input logic [7:0] s, input logic [7:0] kk);
        return {21'h0, s[6:5], 1'b0, kk};
    endfunction : exp_call_pc

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Ready is looked at before the edge so the sample never races the slave
    task automatic bus_wait(output int stalls);
        logic rdy;
        stalls = 0;
        do begin
            @(negedge ref_clk);
            rdy = hreadyout;
            @(posedge ref_clk);
            if (rdy !== 1'b1) stalls++;
        end while (rdy !== 1'b1);
    endtask : bus_wait

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output int stalls);
        int s0;
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        bus_wait(s0);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        bus_wait(stalls);
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        int s0;
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        bus_wait(s0);
        hsel <= 1'b0;
        htrans <= 2'b00;
        bus_wait(s0);
        d = hrdata;
    endtask : bus_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] d;
        bus_rd(a, d);
        check(d & mask, exp);
        check({31'h0, hresp}, 32'h0);
    endtask : rd_chk

    // A write right behind the opcode stalls only while a call is in its second cycle
    task automatic run_op(input logic [11:0] op, input int exp_stall);
        int s;
        bus_wr(ccx_pkg::CCX_OFS_INSTR, {20'h0_0000, op}, s);
        bus_wr(ccx_pkg::CCX_OFS_CTRL, {31'h0, psa}, s);
        check(32'(s), 32'(exp_stall));
    endtask : run_op

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        mismatches = 0;
        n_checks = 0;
        seed = 32'h2901_00e4;
        psa = 1'b1;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        rd_chk(ccx_pkg::CCX_OFS_PROG, 32'hffff_ffff, 32'h0);
        rd_chk(ccx_pkg::CCX_OFS_STATUS, 32'hffff_ffff, {24'h00_0000, ccx_pkg::CCX_STATUS_RST});
        rd_chk(ccx_pkg::CCX_OFS_CTRL, 32'h0000_0001, 32'h1);
        rd_chk(ccx_pkg::CCX_OFS_WREG, 32'hffff_ffff, 32'h0);
        // Calls with boundary targets and a return address that wraps
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            k = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
            pc0 = (i == 2) ? 11'h7ff : seed[31:21];
            sts = seed[19:12];
            bus_rd(ccx_pkg::CCX_OFS_STACK, rd);
            hd = rd[10:0];
            bus_wr(ccx_pkg::CCX_OFS_PROG, {21'h0, pc0}, st);
            bus_wr(ccx_pkg::CCX_OFS_STATUS, {24'h00_0000, sts}, st);
            run_op({ccx_pkg::CCX_CALL_HI, k}, 1);
            rd_chk(ccx_pkg::CCX_OFS_PROG, 32'h0000_07ff, exp_call_pc(sts, k));
            rd_chk(ccx_pkg::CCX_OFS_STACK, 32'h07ff_07ff, {5'h0, hd, 5'h0, 11'(pc0 + 11'h1)});
            rd_chk(ccx_pkg::CCX_OFS_STATUS, 32'h0000_00ff, {24'h00_0000, sts});
        end
        // File clears at both ends of the address range; the neighbour must survive
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            f = (i == 0) ? 5'd0 : (i == 1) ? 5'd31 : seed[4:0];
            bus_wr(fa(f), {24'h00_0000, seed[7:0] | 8'h01}, st);
            bus_wr(fa(f ^ 5'h01), 32'h0000_00a5, st);
            bus_wr(ccx_pkg::CCX_OFS_STATUS, 32'h0000_0018, st);
            run_op({ccx_pkg::CCX_FILE_CLR_HI, f}, 0);
            rd_chk(fa(f), 32'h0000_00ff, 32'h0);
            rd_chk(fa(f ^ 5'h01), 32'h0000_00ff, 32'h0000_00a5);
            rd_chk(ccx_pkg::CCX_OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
        end
        seed = lfsr(seed);
        bus_wr(ccx_pkg::CCX_OFS_WREG, {24'h00_0000, seed[7:0] | 8'h01}, st);
        bus_wr(ccx_pkg::CCX_OFS_STATUS, 32'h0000_0018, st);
        run_op(ccx_pkg::CCX_WREG_CLR_OP, 0);
        rd_chk(ccx_pkg::CCX_OFS_WREG, 32'h0000_00ff, 32'h0);
        rd_chk(ccx_pkg::CCX_OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
        // A neighbour of the call opcode must only step past itself
        bus_rd(ccx_pkg::CCX_OFS_STACK, rd);
        pc0 = seed[26:16];
        bus_wr(ccx_pkg::CCX_OFS_PROG, {21'h0, pc0}, st);
        run_op({4'h8, seed[7:0]}, 0);
        rd_chk(ccx_pkg::CCX_OFS_PROG, 32'h0000_07ff, {21'h0, 11'(pc0 + 11'h1)});
        rd_chk(ccx_pkg::CCX_OFS_STACK, 32'hffff_ffff, rd);
        // Watchdog clear with the prescaler on the watchdog
        repeat (300 + int'(seed[7:0])) @(posedge ref_clk);
        bus_wr(ccx_pkg::CCX_OFS_STATUS, 32'h0, st);
        run_op(ccx_pkg::CCX_DOG_CLR_OP, 0);
        bus_rd(ccx_pkg::CCX_OFS_DOG, rd);
        check({24'h00_0000, rd[7:0]}, 32'h0);
        check(32'(rd[23:16] < 8'h10), 32'h1);
        rd_chk(ccx_pkg::CCX_OFS_STATUS, 32'h0000_0018, 32'h0000_0018);
        // Prescaler handed to the timer must keep its count
        repeat (20 + int'(seed[13:8])) @(posedge ref_clk);
        psa = 1'b0;
        bus_wr(ccx_pkg::CCX_OFS_CTRL, 32'h0, st);
        // Let the counter climb well past the read-back bound so a missed clear shows
        repeat (40) @(posedge ref_clk);
        bus_rd(ccx_pkg::CCX_OFS_DOG, rd);
        p0 = rd[23:16];
        bus_wr(ccx_pkg::CCX_OFS_STATUS, 32'h0, st);
        run_op(ccx_pkg::CCX_DOG_CLR_OP, 0);
        bus_rd(ccx_pkg::CCX_OFS_DOG, rd);
        check({24'h00_0000, rd[23:16]}, {24'h00_0000, p0});
        check(32'(rd[7:0] < 8'h10), 32'h1);
        rd_chk(ccx_pkg::CCX_OFS_STATUS, 32'h0000_0018, 32'h0000_0018);
        end_sim();
    end
endmodule : ccx_core_tb
